// ===== php_chk.sv
// checker: timing relations on the wires between host end and device end
// assumes one clock domain and the async active-low reset of both ends
`timescale 1ns/1ps
module php_chk (
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   input  wire logic       cs_n,
   input  wire logic       bus_style_strap,
   input  wire logic       data_or_read_strobe_n,
   input  wire logic       rw_or_write_strobe,
   input  wire logic [4:0] register_select_lines,
   input  wire logic       dev_data_oe,
   input  wire logic       host_data_oe,
   input  wire logic [7:0] host_data_lines
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   logic rd_cond;
   logic strobe_on;
   assign rd_cond   = !cs_n && !data_or_read_strobe_n && rw_or_write_strobe;
   assign strobe_on = !data_or_read_strobe_n || (bus_style_strap && !rw_or_write_strobe);
   // **********
   // sequences
   // **********
   sequence strobe_pulse_s;
      !data_or_read_strobe_n [*4] ##1 data_or_read_strobe_n;
   endsequence
   sequence setup_s;
      !strobe_on [*2] ##1 strobe_on;
   endsequence
   // **********
   // assertions
   // **********
   read_start_a: assert property ($rose(dev_data_oe) |-> $past(rd_cond, 2) && $past(rd_cond, 3))
      else $error("device drove bus without a read");
   read_stop_a: assert property ($fell(rd_cond) |-> ##[1:4] !dev_data_oe)
      else $error("device kept bus after read");
   idle_quiet_a: assert property (cs_n [*4] |-> !dev_data_oe)
      else $error("device drove bus while deselected");
   host_drive_a: assert property (host_data_oe |-> !cs_n && (bus_style_strap || !rw_or_write_strobe))
      else $error("host drove data outside a write");
   strobe_sel_a: assert property (strobe_on |-> !cs_n)
      else $error("strobe outside select");
   strobe_len_a: assert property ($fell(data_or_read_strobe_n) |-> strobe_pulse_s)
      else $error("strobe length wrong");
   setup_len_a: assert property ($fell(cs_n) |-> setup_s)
      else $error("setup before strobe wrong");
   sel_stable_a: assert property (!cs_n && !$past(cs_n) |-> $stable({register_select_lines, bus_style_strap}))
      else $error("address or style moved in access");
   wdata_stable_a: assert property (host_data_oe && $past(host_data_oe) |-> $stable(host_data_lines))
      else $error("write data moved");
endmodule

// ===== php_device.sv
// device end of the parallel host port: register file, strobe decode, irq
// assumes host pins are asynchronous; all are synchronised before use
`timescale 1ns/1ps
// Functional notes
// RULE1: select high keeps port idle, bus released
// RULE2: held in reset while reset low
// RULE3: host holds reset low one microsecond; the testbench power-up reset ends at the fourth clock edge
// RULE4: host resets device once after power-up
// RULE5: irq pulled low while interrupt pending
// RULE6: irq works regardless of select
// RULE7: eight-bit bidirectional bus, bit0 lsb
// RULE8: strap high separate strobes, low data-strobe
// RULE9: data-strobe style, direction high reads
// RULE10: data-strobe style, direction low writes
// RULE11: separate style, direction pin writes low
// RULE12: five select lines pick register
// RULE13: data-strobe style, shared strobe times access
// RULE14: separate style, shared strobe is read
// RULE15: drive bus only on selected read
module php_device
   import php_pkg::*;
#(
   parameter int NREGS = 32
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_n_in,
   php_if.device                 bus,
   input  wire logic [NREGS-1:0] irq_src_in,
   output logic      [7:0]       reg_index_out,
   output logic      [7:0]       wr_data_out,
   output logic                  wr_stb_out
);
   import php_pkg::*;

   // ****************************************
   // pin synchronisers
   // ****************************************
   // every host pin is asynchronous to mclk_in and passes two flops;
   // control pins reset to their idle high level, so no false strobe follows reset
   logic [3:0] ctrl_raw;
   logic [3:0] ctrl_s;
   logic       cs_n_s;
   logic       strap_s;
   logic       strobe_n_s;
   logic       dir_s;
   logic [4:0] addr_s;
   logic [7:0] wdata_s;

   assign ctrl_raw = {bus.cs_n, bus.bus_style_strap, bus.data_or_read_strobe_n,
                      bus.rw_or_write_strobe};

   php_sync #(.WIDTH(4), .RST_VAL(4'hf)) u_sync_ctrl (
      .mclk_in  (mclk_in),
      .rst_n_in (rst_n_in),
      .d_in     (ctrl_raw),
      .q_out    (ctrl_s)
   );

   // address and data are only read while a synchronised strobe is active,
   // by which time the host has held them steady for several cycles
   php_sync #(.WIDTH(5), .RST_VAL(5'h00)) u_sync_addr (
      .mclk_in  (mclk_in),
      .rst_n_in (rst_n_in),
      .d_in     (bus.register_select_lines),                // RULE12
      .q_out    (addr_s)
   );

   php_sync #(.WIDTH(8), .RST_VAL(8'hff)) u_sync_data (
      .mclk_in  (mclk_in),
      .rst_n_in (rst_n_in),
      .d_in     (bus.host_data_lines),                      // RULE7
      .q_out    (wdata_s)
   );

   assign cs_n_s     = ctrl_s[3];
   assign strap_s    = ctrl_s[2];
   assign strobe_n_s = ctrl_s[1];
   assign dir_s      = ctrl_s[0];

   // ****************************************
   // strobe decode
   // ****************************************
   // both strobes low at once in separate style is illegal; neither is honoured
   logic sep_rd;
   logic sep_wr;
   logic data_or_read_strobe;
   logic ds_wr;
   logic rd_req;
   logic wr_req;

   assign sep_rd = !strobe_n_s && dir_s;                  // RULE14
   assign sep_wr = !dir_s && strobe_n_s;                  // RULE11
   assign data_or_read_strobe  = !strobe_n_s && dir_s;                  // RULE13 RULE9
   assign ds_wr  = !strobe_n_s && !dir_s;                 // RULE13 RULE10

   // a deselected port raises no request at all
   always_comb begin
      rd_req = 1'b0;
      wr_req = 1'b0;
      if (!cs_n_s) begin                                  // RULE1
         if (strap_s) begin                               // RULE8
            rd_req = sep_rd;
            wr_req = sep_wr;
         end else begin
            rd_req = data_or_read_strobe;
            wr_req = ds_wr;
         end
      end
   end

   // ****************************************
   // state
   // ****************************************
   typedef enum logic [1:0] {DEV_IDLE, DEV_READ, DEV_WRITE} php_dev_phase_t;

   typedef struct packed {
      logic [NREGS-1:0][7:0] regs;
      logic [NREGS-1:0]      pend;
      php_dev_phase_t        phase;
      logic [4:0]            addr;
      logic [7:0]            rdata;
      logic [7:0]            wdata;
      logic                  wr_stb;
   } php_dev_t;
   php_dev_t st, next_st;

   // idle to read or write on a synchronised strobe, back to idle when it ends
   always_comb begin
      next_st        = st;
      next_st.wr_stb = 1'b0;
      // pending bits are sticky: no clear path exists, only reset empties them
      next_st.pend   = st.pend | irq_src_in;              // RULE5
      unique case (st.phase)
         DEV_IDLE: begin
            if (rd_req) begin
               next_st.phase = DEV_READ;
               next_st.addr  = addr_s;
               next_st.rdata = st.regs[addr_s];
            end else if (wr_req) begin
               next_st.phase = DEV_WRITE;
               next_st.addr  = addr_s;
               next_st.wdata = wdata_s;
            end
         end
         DEV_READ: begin
            // read data follows the register while the strobe lasts
            if (rd_req) begin
               next_st.addr  = addr_s;
               next_st.rdata = st.regs[addr_s];
            end else begin
               next_st.phase = DEV_IDLE;
            end
         end
         DEV_WRITE: begin
            // a write lands once, as the strobe ends, with its last active values
            if (wr_req) begin
               next_st.addr  = addr_s;
               next_st.wdata = wdata_s;
            end else begin
               next_st.regs[st.addr] = st.wdata;          // RULE12
               next_st.wr_stb        = 1'b1;
               next_st.phase         = DEV_IDLE;
            end
         end
         default: begin
            next_st.phase = DEV_IDLE;
         end
      endcase
   end

   // registers, pending bits and phase all clear in reset
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin                                // RULE2
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // interrupt request
   // ****************************************
   // bit0 of register g lets pending bit g reach the request line
   logic [NREGS-1:0] irq_masked;
   logic             irq_pending;

   for (genvar g = 0; g < NREGS; g++) begin : g_irq
      assign irq_masked[g] = st.pend[g] & st.regs[g][0];
   end

   assign irq_pending = |irq_masked;
   // open drain: the enable pulls the line low and select plays no part
   assign bus.irq_oe = irq_pending;                       // RULE5 RULE6

   // ****************************************
   // data bus and user side
   // ****************************************
   // the bus turns only after the read has held two synchronised cycles,
   // so a one-cycle glitch on the strobe never drives it
   assign bus.dev_data    = st.rdata;
   assign bus.dev_data_oe = (st.phase == DEV_READ) && rd_req;   // RULE15 RULE1
   // user side: last address, last write data and the landing pulse
   assign reg_index_out   = {3'h0, st.addr};
   assign wr_data_out     = st.wdata;
   assign wr_stb_out      = st.wr_stb;
endmodule

// ===== php_host.sv
// host end: runs one read or write access on the parallel port per request
// assumes request inputs come from logic on the same clock
`timescale 1ns/1ps
module php_host
   import php_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   input  wire logic       style_in,
   input  wire logic       req_in,
   input  wire logic       req_write_in,
   input  wire logic [4:0] req_addr_in,
   input  wire logic [7:0] req_wdata_in,
   output logic            busy_out,
   output logic            done_out,
   output logic      [7:0] rdata_out,
   output logic            irq_out,
   php_if.host             bus
);
   import php_pkg::*;
   typedef struct packed {
      php_host_state_t state;
      logic [3:0]      cnt;
      logic            wr;
      logic [4:0]      addr;
      logic [7:0]      wdata;
      logic [7:0]      rdata;
      logic            done;
      logic [1:0]      irq_sync;
   } php_host_st_t;
   php_host_st_t st, next_st;

   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      next_st.irq_sync = {st.irq_sync[0], bus.irq_n};
      next_st.cnt  = st.cnt + 4'h1;
      unique case (st.state)
         PHP_IDLE: begin
            next_st.cnt = 4'h0;
            if (req_in) begin
               next_st.state = PHP_SETUP;
               next_st.wr    = req_write_in;
               next_st.addr  = req_addr_in;
               next_st.wdata = req_wdata_in;
            end
         end
         PHP_SETUP: if (st.cnt == 4'(SETUP_CYC - 1)) begin
            next_st.state = PHP_STROBE;
            next_st.cnt   = 4'h0;
         end
         PHP_STROBE: if (st.cnt == 4'(STROBE_CYC - 1)) begin
            next_st.state = PHP_HOLD;
            next_st.cnt   = 4'h0;
            next_st.rdata = bus.host_data_lines;
         end
         PHP_HOLD: if (st.cnt == 4'(HOLD_CYC - 1)) begin
            next_st.state = PHP_IDLE;
            next_st.done  = 1'b1;
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // request synchroniser starts released: no false irq after reset
         st <= '{state: PHP_IDLE, irq_sync: 2'b11, default: '0};
      end else begin
         st <= next_st;
      end
   end

   logic active;
   logic strobe;
   assign active = (st.state != PHP_IDLE);
   assign strobe = (st.state == PHP_STROBE);
   assign bus.cs_n                  = !active;                              // RULE1
   assign bus.bus_style_strap       = style_in;                             // RULE8
   assign bus.register_select_lines = st.addr;                              // RULE12
   // data-strobe style: direction steady, strobe pulses; separate: own strobes
   assign bus.data_or_read_strobe_n = style_in ? !(strobe && !st.wr)
                                               : !strobe;                   // RULE13 RULE14
   assign bus.rw_or_write_strobe    = style_in ? !(strobe && st.wr)
                                               : !st.wr;                    // RULE9 RULE10 RULE11
   assign bus.host_data             = st.wdata;                             // RULE7
   assign bus.host_data_oe          = active && st.wr;
   assign busy_out  = active;
   assign done_out  = st.done;
   assign rdata_out = st.rdata;
   assign irq_out   = !st.irq_sync[1];
endmodule

// ===== php_if.sv
// interface joining the device end and the host end of the parallel port
// resolves the tristate data bus and the open-drain interrupt from enables
`timescale 1ns/1ps
interface php_if;
   logic       cs_n;
   logic       bus_style_strap;
   logic       data_or_read_strobe_n;
   logic       rw_or_write_strobe;
   logic [4:0] register_select_lines;
   logic [7:0] dev_data;
   logic       dev_data_oe;
   logic [7:0] host_data;
   logic       host_data_oe;
   logic       irq_oe;
   logic [7:0] host_data_lines;
   logic       irq_n;
   // pull-up when nobody drives
   assign host_data_lines = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);
   assign irq_n = irq_oe ? 1'b0 : 1'b1;
   modport device (input cs_n, bus_style_strap, data_or_read_strobe_n, rw_or_write_strobe,
                   register_select_lines, host_data_lines,
                   output dev_data, dev_data_oe, irq_oe);
   modport host (output cs_n, bus_style_strap, data_or_read_strobe_n, rw_or_write_strobe,
                 register_select_lines, host_data, host_data_oe,
                 input host_data_lines, irq_n);
endinterface

// ===== php_pkg.sv
// package for the parallel host port: widths, timing and the host state enum
// assumes a single 25 MHz clock shared by both ends
package php_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 5;
   // reset hold time in ns and the clock period
   localparam int RESET_HOLD_NS = 1000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // host strobe phase lengths in cycles
   localparam int SETUP_CYC  = 2;
   localparam int STROBE_CYC = 4;
   localparam int HOLD_CYC   = 2;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   typedef enum logic [1:0] {PHP_IDLE, PHP_SETUP, PHP_STROBE, PHP_HOLD} php_host_state_t;
endpackage

// ===== php_sync.sv
// two-flop synchroniser bank for pins arriving from outside the clock domain
// assumes asynchronous active-low reset
`timescale 1ns/1ps
module php_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] q;
   } php_sync_t;
   php_sync_t st, next_st;
   always_comb begin
      next_st.meta = d_in;
      next_st.q    = st.meta;
   end
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= {RST_VAL, RST_VAL};
      end else begin
         st <= next_st;
      end
   end
   assign q_out = st.q;
endmodule

// ===== testbench.sv
// testbench: host end and device end joined, driven from user sides
// assumes php_if, php_host, php_device and php_chk are compiled first
`timescale 1ns/1ps
module testbench;
   import php_pkg::*;
   logic        mclk_in, rst_n_in, style_in, req_in, req_write_in;
   logic        busy_out, done_out, irq_out, wr_stb_out;
   logic [4:0]  req_addr_in, wire_a;
   logic [7:0]  req_wdata_in, rdata_out, reg_index_out, wr_data_out, wire_w, wire_r, dv;
   logic [31:0] irq_src_in;
   int          err_count, cmp_count, i;
   php_if u_php_if ();
   php_device #(.NREGS(32)) u_php_device (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .bus(u_php_if), .irq_src_in(irq_src_in), .reg_index_out(reg_index_out),
      .wr_data_out(wr_data_out), .wr_stb_out(wr_stb_out));
   php_host u_php_host (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .style_in(style_in),
      .req_in(req_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
      .req_wdata_in(req_wdata_in), .busy_out(busy_out), .done_out(done_out),
      .rdata_out(rdata_out), .irq_out(irq_out), .bus(u_php_if));
   php_chk u_php_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cs_n(u_php_if.cs_n),
      .bus_style_strap(u_php_if.bus_style_strap),
      .data_or_read_strobe_n(u_php_if.data_or_read_strobe_n),
      .rw_or_write_strobe(u_php_if.rw_or_write_strobe),
      .register_select_lines(u_php_if.register_select_lines),
      .dev_data_oe(u_php_if.dev_data_oe), .host_data_oe(u_php_if.host_data_oe),
      .host_data_lines(u_php_if.host_data_lines));
   initial begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end
   // **********
   // wire monitor
   // **********
   always @(negedge mclk_in) begin
      if (!u_php_if.cs_n) wire_a = u_php_if.register_select_lines;
      if (u_php_if.host_data_oe) wire_w = u_php_if.host_data_lines;
      if (u_php_if.dev_data_oe) wire_r = u_php_if.host_data_lines;
   end
   // **********
   // tasks
   // **********
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      req_in <= 1'b1;
      req_write_in <= w;
      req_addr_in <= a;
      req_wdata_in <= d;
      @(posedge mclk_in);
      req_in <= 1'b0;
      @(negedge mclk_in);
      chk("busy", 8'h01, {7'h0, busy_out});
      i = 0;
      do begin @(negedge mclk_in); i++; end while (done_out !== 1'b1 && i < 20);
      chk("done", 8'h01, {7'h0, done_out});
      chk("idle busy", 8'h00, {7'h0, busy_out});
      chk("wire addr", {3'h0, a}, {3'h0, wire_a});
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      access(1'b1, a, d);
      i = 0;
      while (wr_stb_out !== 1'b1 && i < 10) begin @(negedge mclk_in); i++; end
      chk("write index", {3'h0, a}, reg_index_out);
      chk("write data", d, wr_data_out);
      chk("wire write", d, wire_w);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      access(1'b0, a, 8'h00);
      chk("read data", e, rdata_out);
      chk("wire read", e, wire_r);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // **********
   // tests
   // **********
   initial begin
      {rst_n_in, req_in, req_write_in, req_addr_in, req_wdata_in, irq_src_in} = '0;
      style_in = 1'b1;
      err_count = 0;
      cmp_count = 0;
      repeat (4) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      for (int s = 1; s >= 0; s--) begin
         @(posedge mclk_in);
         style_in <= s[0];
         dv = s[0] ? 8'h81 : 8'h4c;
         wr(5'h00, dv);
         wr(5'h1f, ~dv);
         rd(5'h00, dv);
         rd(5'h1f, ~dv);
         chk("idle cs", 8'h01, {7'h0, u_php_if.cs_n});
         chk("idle bus", 8'hff, u_php_if.host_data_lines);
      end
      // pending source with enable clear must stay quiet
      @(posedge mclk_in);
      irq_src_in[3] <= 1'b1;
      repeat (3) @(posedge mclk_in);
      irq_src_in[3] <= 1'b0;
      repeat (8) @(negedge mclk_in);
      chk("masked irq", 8'h01, {7'h0, u_php_if.irq_n});
      wr(5'h03, 8'h01);
      i = 0;
      while (u_php_if.irq_n !== 1'b0 && i < 10) begin @(negedge mclk_in); i++; end
      chk("irq pin", 8'h00, {7'h0, u_php_if.irq_n});
      chk("irq cs", 8'h01, {7'h0, u_php_if.cs_n});
      repeat (3) @(negedge mclk_in);
      chk("irq seen", 8'h01, {7'h0, irq_out});
      // reset in mid-run clears registers and releases irq
      @(posedge mclk_in);
      rst_n_in <= 1'b0;
      repeat (RESET_HOLD_CYC) @(posedge mclk_in);
      chk("reset irq", 8'h01, {7'h0, u_php_if.irq_n});
      chk("reset cs", 8'h01, {7'h0, u_php_if.cs_n});
      rst_n_in <= 1'b1;
      rd(5'h1f, REG_RESET_VAL);
      rd(5'h03, REG_RESET_VAL);
      chk("irq after reset", 8'h01, {7'h0, u_php_if.irq_n});
      end_of_test();
   end
   // run needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge mclk_in);
      err_count++;
      end_of_test();
   end
endmodule
